/* common/shbp_pkg.sv */
// package: constants and types of the slave host buffer port
// ==========================================================
// Contract
// - every master buffer write copies the register select line into command_data_flag
// - output_full_flag sets on internal load, clears when master reads it
// - internal load of the output buffer only while output-full is clear
// - master write sets input-full; buffer valid only while input-full set
// - flag-pin enable: port2 bit4 shows output-full, bit5 inverted input-full
// - each flag pin shows its flag only while its port latch bit is one
// - dma enable: port2 bit6 is dma request, bit7 acknowledge input
// - command bit1 selects port 1, bit2 port 2; neither bit: no change
// - port selection persists in user_flag_zero until other port selected
// - user_flag_zero set on invalid read command or read while output-full
// - internal read clears input-full; internal write sets output-full
// - internal logic writes upper four status bits, readable by master
// - with interrupt enabled a master write raises internal interrupt to 03h
// - dma request clears on acknowledge with strobe; acknowledge forces select low
package shbp_pkg;
	localparam int DATA_W = 8;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] IRQ_VECTOR = 8'h03;
	localparam int ST_OUT_FULL = 0;
	localparam int ST_IN_FULL  = 1;
	localparam int ST_USER0    = 2;
	localparam int ST_CMDDATA  = 3;
	localparam int ST_USER_LO  = 4;
	localparam int BIT_OBF_PIN = 4;
	localparam int BIT_IBF_PIN = 5;
	localparam int BIT_DRQ_PIN = 6;
	localparam int BIT_ACK_PIN = 7;
	localparam int CMD_PORT1   = 1;
	localparam int CMD_PORT2   = 2;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       sel;
		logic [7:0] data;
	} shbp_host_t;

	typedef enum logic [1:0] {SHBP_NONE, SHBP_P1, SHBP_P2, SHBP_BAD} shbp_cmd_t;
endpackage : shbp_pkg

/* core/shbp_sync.sv */
// two-flop synchroniser for asynchronous host pins
`timescale 1ns/1ps
module shbp_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	// ==========================================================
	// sync chain
	// reset value is idle-high: strobes are active low
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta_reg <= '1;
			q_reg    <= '1;
		end else begin
			meta_reg <= i_d;
			q_reg    <= meta_reg;
		end
	end
	assign o_q = q_reg;
endmodule : shbp_sync

/* core/shbp_port.sv */
// host data bus buffer with flags, flag pins and dma handshake
`timescale 1ns/1ps
module shbp_port
	import shbp_pkg::*;
(
	input  wire logic                I_CLOCK,
	input  wire logic                I_NRST,
	input  wire shbp_pkg::shbp_host_t I_HOST,
	input  wire logic                I_DMA_ACK_N,
	output logic [7:0]               O_HOST_DATA,
	output logic                     O_HOST_DATA_OE_N,
	input  wire logic                I_IN_READ,
	input  wire logic                I_OUT_LOAD,
	input  wire logic [7:0]          I_OUT_DATA,
	input  wire logic                I_STS_LOAD,
	input  wire logic [3:0]          I_STS_DATA,
	input  wire logic                I_FLAG_EN,
	input  wire logic                I_DMA_EN,
	input  wire logic                I_IRQ_EN,
	input  wire logic                I_IRQ_ACK,
	input  wire logic [7:0]          I_P2_LATCH,
	input  wire logic                I_PORT_READ_MODE,
	output logic [7:0]               O_IN_DATA,
	output logic                     O_IN_FULL,
	output logic                     O_OUT_FULL,
	output logic                     O_CMD_DATA,
	output logic                     O_USER0,
	output logic                     O_PORT_SEL,
	output logic                     O_P1_WRITE,
	output logic                     O_P2_WRITE,
	output logic [7:0]               O_PORT_DATA,
	output logic                     O_IRQ_PEND,
	output logic [7:0]               O_IRQ_VECTOR,
	output logic [7:0]               O_P2_PINS
);
	import shbp_pkg::*;

	shbp_host_t host_s;
	logic       ack_s;
	logic [7:0] in_reg, in_next, out_reg, out_next;
	logic       ibf_reg, ibf_next, obf_reg, obf_next;
	logic       cd_reg, cd_next, f0_reg, f0_next;
	logic [3:0] usr_reg, usr_next;
	logic       drq_reg, drq_next, pend_reg, pend_next;
	logic       flg_reg, flg_next, dma_reg, dma_next;
	logic       wr_d_reg, rd_d_reg;
	logic [7:0] rdat_reg, rdat_next;
	logic       oe_n_reg, oe_n_next;
	logic       p1w_reg, p1w_next, p2w_reg, p2w_next;
	logic [7:0] pdat_reg, pdat_next, pins_reg, pins_next;
	logic       cs_eff, sel_eff, wr_act, rd_act, wr_rise, rd_rise;
	// select and data are captured while the strobe is low, because the
	// master may change them in the same cycle that it releases the strobe
	logic       sel_d_reg, sel_d_next, p26_d_reg;
	logic [7:0] wdat_reg, wdat_next, vec_reg;
	shbp_cmd_t  cmd;

	// ==========================================================
	// pin synchronisers
	shbp_sync #(.W($bits(shbp_host_t) + 1)) u_sync (
		.i_clk  (I_CLOCK),
		.i_nrst (I_NRST),
		.i_d    ({I_HOST, I_DMA_ACK_N}),
		.o_q    ({host_s, ack_s})
	);

	// ==========================================================
	// host access decode
	always_comb begin
		// acknowledge forces chip select and register select low
		cs_eff  = host_s.cs_n & ~(dma_reg & ~ack_s);
		sel_eff = host_s.sel & ~(dma_reg & ~ack_s);
		wr_act  = ~cs_eff & ~host_s.wr_n;
		rd_act  = ~cs_eff & ~host_s.rd_n;
		// act once per strobe, on its trailing edge
		wr_rise = wr_d_reg & ~wr_act;
		rd_rise = rd_d_reg & ~rd_act;
		sel_d_next = sel_d_reg;
		wdat_next  = wdat_reg;
		if (wr_act || rd_act) begin
			sel_d_next = sel_eff;
			wdat_next  = host_s.data;
		end
		cmd = SHBP_BAD;
		if (in_reg[CMD_PORT1])
			cmd = SHBP_P1;
		else if (in_reg[CMD_PORT2])
			cmd = SHBP_P2;
		else if (!I_PORT_READ_MODE)
			cmd = SHBP_NONE;
	end

	// ==========================================================
	// buffers and flags
	always_comb begin
		in_next  = in_reg;
		out_next = out_reg;
		ibf_next = ibf_reg;
		obf_next = obf_reg;
		cd_next  = cd_reg;
		f0_next  = f0_reg;
		usr_next = usr_reg;
		pend_next = pend_reg;
		flg_next = flg_reg | I_FLAG_EN;
		dma_next = dma_reg | I_DMA_EN;
		p1w_next = 1'b0;
		p2w_next = 1'b0;
		pdat_next = pdat_reg;
		// internal read consumes the byte; only valid while full
		if (I_IN_READ && ibf_reg) begin
			ibf_next = 1'b0;
			if (I_PORT_READ_MODE) begin
				if (cmd == SHBP_BAD || obf_reg)
					f0_next = 1'b1;
			end else if (cd_reg) begin
				if (cmd == SHBP_P1)
					f0_next = 1'b0;
				else if (cmd == SHBP_P2)
					f0_next = 1'b1;
			end else begin
				p1w_next  = ~f0_reg;
				p2w_next  = f0_reg;
				pdat_next = in_reg;
			end
		end
		// master read of the output buffer clears output-full
		if (rd_rise && !sel_d_reg)
			obf_next = 1'b0;
		// load refused while master still owns the previous byte
		if (I_OUT_LOAD && !obf_reg) begin
			out_next = I_OUT_DATA;
			obf_next = 1'b1;
		end
		if (I_STS_LOAD)
			usr_next = I_STS_DATA;
		if (I_IRQ_ACK)
			pend_next = 1'b0;
		// set wins over the internal read clear
		if (wr_rise) begin
			in_next  = wdat_reg;
			ibf_next = 1'b1;
			cd_next  = sel_d_reg;
			if (I_IRQ_EN)
				pend_next = 1'b1;
		end
	end

	// ==========================================================
	// dma request, read data and pins
	always_comb begin
		drq_next = drq_reg;
		// edge of the latch bit itself, so a cleared request stays cleared
		if (dma_reg && I_P2_LATCH[BIT_DRQ_PIN] && !p26_d_reg)
			drq_next = 1'b1;
		if (dma_reg && !ack_s && (rd_act || wr_act))
			drq_next = 1'b0;
		if (!dma_reg)
			drq_next = 1'b0;
		oe_n_next = ~rd_act;
		rdat_next = sel_eff ? {usr_reg, cd_reg, f0_reg, ibf_reg, obf_reg}
			: out_reg;
		pins_next = I_P2_LATCH;
		if (flg_reg) begin
			pins_next[BIT_OBF_PIN] = I_P2_LATCH[BIT_OBF_PIN] & obf_reg;
			pins_next[BIT_IBF_PIN] = I_P2_LATCH[BIT_IBF_PIN] & ~ibf_reg;
		end
		if (dma_reg) begin
			pins_next[BIT_DRQ_PIN] = drq_next;
			pins_next[BIT_ACK_PIN] = 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			in_reg <= RESET_BYTE;
			out_reg <= RESET_BYTE;
			ibf_reg <= 1'b0;
			obf_reg <= 1'b0;
			cd_reg <= 1'b0;
			f0_reg <= 1'b0;
			usr_reg <= 4'h0;
			drq_reg <= 1'b0;
			pend_reg <= 1'b0;
			flg_reg <= 1'b0;
			dma_reg <= 1'b0;
			wr_d_reg <= 1'b0;
			rd_d_reg <= 1'b0;
			rdat_reg <= RESET_BYTE;
			oe_n_reg <= 1'b1;
			p1w_reg <= 1'b0;
			p2w_reg <= 1'b0;
			pdat_reg <= RESET_BYTE;
			pins_reg <= RESET_BYTE;
			sel_d_reg <= 1'b0;
			wdat_reg <= RESET_BYTE;
			p26_d_reg <= 1'b0;
			vec_reg <= IRQ_VECTOR;
		end else begin
			in_reg <= in_next;
			out_reg <= out_next;
			ibf_reg <= ibf_next;
			obf_reg <= obf_next;
			cd_reg <= cd_next;
			f0_reg <= f0_next;
			usr_reg <= usr_next;
			drq_reg <= drq_next;
			pend_reg <= pend_next;
			flg_reg <= flg_next;
			dma_reg <= dma_next;
			wr_d_reg <= wr_act;
			rd_d_reg <= rd_act;
			rdat_reg <= rdat_next;
			oe_n_reg <= oe_n_next;
			p1w_reg <= p1w_next;
			p2w_reg <= p2w_next;
			pdat_reg <= pdat_next;
			pins_reg <= pins_next;
			sel_d_reg <= sel_d_next;
			wdat_reg <= wdat_next;
			p26_d_reg <= I_P2_LATCH[BIT_DRQ_PIN];
			vec_reg <= IRQ_VECTOR;
		end
	end

	assign O_HOST_DATA = rdat_reg;
	assign O_HOST_DATA_OE_N = oe_n_reg;
	assign O_IN_DATA = in_reg;
	assign O_IN_FULL = ibf_reg;
	assign O_OUT_FULL = obf_reg;
	assign O_CMD_DATA = cd_reg;
	assign O_USER0 = f0_reg;
	assign O_PORT_SEL = f0_reg;
	assign O_P1_WRITE = p1w_reg;
	assign O_P2_WRITE = p2w_reg;
	assign O_PORT_DATA = pdat_reg;
	assign O_IRQ_PEND = pend_reg;
	assign O_IRQ_VECTOR = vec_reg;
	assign O_P2_PINS = pins_reg;

	// ==========================================================
	// checks
	a_write_sets_ibf: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		wr_rise |=> ibf_reg) else $error("write did not set input full");
	a_write_copies_sel: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		wr_rise |=> cd_reg == $past(sel_d_reg)) else $error("cmd flag wrong");
	a_load_sets_obf: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		I_OUT_LOAD && !obf_reg |=> obf_reg && out_reg == $past(I_OUT_DATA))
		else $error("load did not set output full");
	a_load_blocked: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		obf_reg && !(rd_rise && !sel_d_reg) |=> $stable(out_reg))
		else $error("output overwritten while full");
	a_read_clears_ibf: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		I_IN_READ && ibf_reg && !wr_rise |=> !ibf_reg)
		else $error("internal read kept input full");
	a_flag_pin_obf: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		flg_reg |=> pins_reg[BIT_OBF_PIN] ==
		($past(obf_reg) & $past(I_P2_LATCH[BIT_OBF_PIN])))
		else $error("flag pin mismatch");
	a_irq_pending: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		wr_rise && I_IRQ_EN |=> pend_reg) else $error("no interrupt");
	a_reset_clears: assert property (@(posedge I_CLOCK)
		!I_NRST |=> !ibf_reg && !obf_reg && !cd_reg && !flg_reg && !dma_reg)
		else $error("reset did not clear flags");
endmodule : shbp_port

/* bench/shbp_master.sv */
// master processor model on the host bus
`timescale 1ns/1ps
module shbp_master
	import shbp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic [7:0] i_data,
	output shbp_pkg::shbp_host_t o_host
);
	initial o_host = {4'he, 8'h00};
	// ==========
	// bus cycles
	// strobes held 5 low, 4 high: the pins are synced two flops deep
	task automatic cyc(input logic r, input logic s, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_host <= {1'b0, ~r, r, s, d};
		repeat (5) @(posedge i_clk);
		q = i_data;
		// released bus floats: show the inverse of the last byte
		o_host <= {4'he, ~d};
		repeat (4) @(posedge i_clk);
	endtask : cyc
	task automatic wr(input logic s, input logic [7:0] d);
		logic [7:0] q;
		q = 8'hff;
		for (int i = 0; i < 20 && q[ST_IN_FULL] !== 1'b0; i++)
			cyc(1'b1, 1'b1, 8'h00, q);
		cyc(1'b0, s, d, q);
	endtask : wr
	task automatic rd(input logic s, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < 20 && !s && q[ST_OUT_FULL] !== 1'b1; i++)
			cyc(1'b1, 1'b1, 8'h00, q);
		cyc(1'b1, s, 8'h00, q);
	endtask : rd
endmodule : shbp_master

/* bench/test_slave_host_buffer_port.sv */
// self-checking bench of the slave host buffer port
`timescale 1ns/1ps
module test_slave_host_buffer_port;
	import shbp_pkg::*;
	logic       clk = 1'b0, nrst = 1'b0, ack_n = 1'b1;
	logic       irq_en = 1'b0, mode = 1'b0;
	logic [5:0] pls = '0;
	logic [3:0] sdat = 4'h0;
	logic [7:0] odat = 8'h00, latch = 8'h00;
	logic [7:0] q, hdat, idat, pdat, vec, pins, p_last;
	logic       oe_n, ifull, ofull, cmdd, user0, psel, p1w, p2w, irq;
	shbp_host_t host;
	int         fails = 0, n_tests = 0, n_p1 = 0, n_p2 = 0;
	always #2.5 clk = ~clk;
	shbp_master m (.i_clk(clk), .i_data(hdat), .o_host(host));
	shbp_port dut (.I_CLOCK(clk), .I_NRST(nrst), .I_HOST(host),
		.I_DMA_ACK_N(ack_n), .O_HOST_DATA(hdat), .O_HOST_DATA_OE_N(oe_n),
		.I_IN_READ(pls[0]), .I_OUT_LOAD(pls[1]), .I_OUT_DATA(odat),
		.I_STS_LOAD(pls[2]), .I_STS_DATA(sdat), .I_FLAG_EN(pls[3]),
		.I_DMA_EN(pls[4]), .I_IRQ_EN(irq_en), .I_IRQ_ACK(pls[5]),
		.I_P2_LATCH(latch), .I_PORT_READ_MODE(mode), .O_IN_DATA(idat),
		.O_IN_FULL(ifull), .O_OUT_FULL(ofull), .O_CMD_DATA(cmdd),
		.O_USER0(user0), .O_PORT_SEL(psel), .O_P1_WRITE(p1w),
		.O_P2_WRITE(p2w), .O_PORT_DATA(pdat), .O_IRQ_PEND(irq),
		.O_IRQ_VECTOR(vec), .O_P2_PINS(pins));
	always @(posedge clk) begin
		if (p1w === 1'b1) n_p1 <= n_p1 + 1;
		if (p2w === 1'b1) n_p2 <= n_p2 + 1;
		if ((p1w | p2w) === 1'b1) p_last <= pdat;
	end
	// =======
	// helpers
	task automatic chk(input string n, input logic [7:0] e, g);
		#1;
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic pulse(input int b);
		@(posedge clk);
		pls[b] <= 1'b1;
		@(posedge clk);
		pls <= '0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic close_out;
		$display("checks %0d unexpected %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// =====
	// tests
	task automatic t_data;
		chk("in_full", 0, ifull);
		chk("out_full", 0, ofull);
		chk("vector", 8'h03, vec);
		irq_en <= 1'b1;
		m.wr(1'b0, 8'h5a);
		chk("in_data", 8'h5a, idat);
		chk("cmd_data", 0, cmdd);
		chk("irq", 1, irq);
		m.rd(1'b1, q);
		chk("status", 8'h02, q);
		pulse(5);
		pulse(0);
		chk("in_full", 0, ifull);
		chk("port1", 8'h5a, p_last);
		chk("irq", 0, irq);
		$display("done data");
	endtask : t_data
	task automatic t_sel;
		logic [7:0] c [3] = '{8'h04, 8'hf9, 8'h02};
		logic       u [3] = '{1'b1, 1'b1, 1'b0};
		int         k;
		for (int i = 0; i < 3; i++) begin
			m.wr(1'b1, c[i]);
			chk("cmd_data", 1, cmdd);
			pulse(0);
			chk("user0", u[i], user0);
			k = n_p2;
			m.wr(1'b0, ~c[i]);
			pulse(0);
			chk("port_data", ~c[i], p_last);
			chk("port2", u[i], 8'(n_p2 - k));
		end
		$display("done select");
	endtask : t_sel
	task automatic t_out;
		odat <= 8'hc3;
		pulse(1);
		chk("out_full", 1, ofull);
		odat <= 8'h11;
		pulse(1);
		sdat <= 4'ha;
		pulse(2);
		m.rd(1'b1, q);
		chk("status", 8'ha1, q);
		m.rd(1'b0, q);
		chk("out_buf", 8'hc3, q);
		chk("out_full", 0, ofull);
		$display("done output");
	endtask : t_out
	task automatic t_misc;
		latch <= 8'h30;
		pulse(3);
		chk("pins", 8'h20, pins & 8'h30);
		m.wr(1'b0, 8'h77);
		pulse(1);
		chk("pins", 8'h10, pins & 8'h30);
		latch <= 8'h00;
		pulse(0);
		chk("pins", 8'h00, pins & 8'h30);
		m.rd(1'b0, q);
		mode <= 1'b1;
		m.wr(1'b1, 8'h01);
		pulse(0);
		chk("user0", 1, user0);
		pulse(4);
		latch <= 8'h40;
		repeat (3) @(posedge clk);
		chk("pins", 8'hc0, pins & 8'hc0);
		ack_n <= 1'b0;
		m.cyc(1'b1, 1'b1, 8'h00, q);
		ack_n <= 1'b1;
		chk("drq", 8'h00, pins & 8'h40);
		$display("done pins");
	endtask : t_misc
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_data;
		t_sel;
		t_out;
		t_misc;
		close_out;
	end
	initial begin
		#200000;
		fails++;
		close_out;
	end
endmodule : test_slave_host_buffer_port
